// file: bench/link_partner.sv
// Far-side data-link model: framer strobes, line bits, transmit clock
`timescale 1ns/1ps
module link_partner (
    // Clock and control
    input  wire ref_clk,
    input  wire tclkRun,
    // Transmit side
    input  wire txLinkBit,
    output reg  txBitStb = 1'b0,
    output reg  txClockPin = 1'b0,
    // Receive side
    output reg  rxBitStb = 1'b0,
    output reg  rxBitIn = 1'b0
);
    reg [1:0] div = 2'h0;
    integer   i;
    integer   j;
    ////////////////////////////////////////////////////////////////////////
    // Transmit clock toggles only while enabled
    always @(posedge ref_clk)
    begin
        div <= div + 2'h1;
        if (tclkRun && div == 2'h0)
            txClockPin <= ~txClockPin;
    end
    ////////////////////////////////////////////////////////////////////////
    // Line bits LSB first; between bits the data line shows the inverse
    task sendBits(input [31:0] v, input integer n);
        for (i = 0; i < n; i = i + 1)
        begin
            rxBitStb <= 1'b1;
            rxBitIn <= v[i];
            @(posedge ref_clk);
            rxBitStb <= 1'b0;
            rxBitIn <= ~v[i];
            @(posedge ref_clk);
        end
    endtask
    // Framer pulls transmit bits at the same pace
    task grab(input integer n, output [31:0] v);
        begin
            v = 32'h00000000;
            for (j = 0; j < n; j = j + 1)
            begin
                txBitStb <= 1'b1;
                @(posedge ref_clk);
                txBitStb <= 1'b0;
                @(posedge ref_clk);
                v[j] = txLinkBit;
            end
        end
    endtask
endmodule

// file: bench/t1_bit_oriented_code_controller_test.sv
// Self-checking bench for the T1 code controller
`timescale 1ns/1ps
module t1_bit_oriented_code_controller_test;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic        t1Mode = 1'b0;
    logic        ais = 1'b0;
    logic        tclkRun = 1'b1;
    logic [8:0]  adr = 9'h000;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] cap;
    logic [7:0]  rv;
    logic [2:0]  f;
    logic [3:0]  k;
    wire         ack, txBitStb, txClockPin, txLinkBit;
    wire         rxBitStb, rxBitIn, intOut;
    integer      bad_count = 0;
    integer      n_compared = 0;
    integer      cycles = 0;
    integer      i;
    logic [6:0]  ix [7] = '{7'h18, 7'h19, 7'h1F, 7'h50, 7'h52, 7'h53, 7'h20};
    logic [7:0]  wv [7] = '{8'hFF, 8'hFF, 8'h06, 8'hFF, 8'hA5, 8'h3C, 8'h77};
    logic [7:0]  ev [7] = '{8'h00, 8'hFF, 8'h06, 8'h00, 8'hA5, 8'h3C, 8'h00};
    always #25 ref_clk = ~ref_clk;
    t1_code_controller #(.SCALED_DIV(2)) uut (
        .ref_clk(ref_clk), .nrst(nrst), .cyc_i(req), .stb_i(req),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .t1ModePin(t1Mode),
        .txClockPin(txClockPin), .txBitStb(txBitStb),
        .txLinkBit(txLinkBit), .rxBitStb(rxBitStb), .rxBitIn(rxBitIn),
        .aisCiDetect(ais), .intOut(intOut)
    );
    link_partner lp (
        .ref_clk(ref_clk), .tclkRun(tclkRun), .txLinkBit(txLinkBit),
        .txBitStb(txBitStb), .txClockPin(txClockPin),
        .rxBitStb(rxBitStb), .rxBitIn(rxBitIn)
    );
    ////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp)
            begin
                bad_count = bad_count + 1;
                $display("MISMATCH at %0t: seen %h expected %h", $time,
                         seen, exp);
            end
        end
    endtask
    task wb(input [6:0] idx, input w, input [7:0] d);
        begin
            req <= 1'b1;
            we <= w;
            adr <= {idx, 2'b00};
            wdat <= {24'h000000, d};
            @(posedge ref_clk);
            while (ack !== 1'b1)
                @(posedge ref_clk);
            rv = rdat[7:0];
            req <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task rchk(input [6:0] idx, input [7:0] m, input [7:0] e);
        begin
            wb(idx, 1'b0, 8'h00);
            check({24'h000000, rv & m}, {24'h000000, e});
        end
    endtask
    task summarize;
        begin
            $display("compared %0d, mismatches %0d", n_compared, bad_count);
            if (bad_count == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count = bad_count + 1;
            summarize;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        for (i = 0; i < 7; i = i + 1)
        begin
            rchk(ix[i], 8'hFF, 8'h00);
            wb(ix[i], 1'b1, wv[i]);
            rchk(ix[i], 8'hFF, ev[i]);
        end
        wb(7'h1F, 1'b1, 8'h00);
        wb(7'h51, 1'b1, 8'hB4);
        lp.grab(8, cap);
        check(cap, 32'h000000B4);
        rchk(7'h18, 8'h04, 8'h04);
        wb(7'h1F, 1'b1, 8'h01);
        lp.grab(8, cap);
        check(cap, 32'h000000B4);
        t1Mode <= 1'b1;
        wb(7'h1F, 1'b1, 8'h00);
        wb(7'h51, 1'b1, 8'hEB);
        wb(7'h1F, 1'b1, 8'h01);
        lp.grab(32, cap);
        check(cap, 32'h56FF56FF);
        wb(7'h1F, 1'b1, 8'h00);
        tclkRun <= 1'b0;
        repeat (60) @(posedge ref_clk);
        rchk(7'h18, 8'h40, 8'h40);
        tclkRun <= 1'b1;
        ais <= 1'b1;
        @(posedge ref_clk);
        ais <= 1'b0;
        rchk(7'h18, 8'h80, 8'h80);
        t1Mode <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ais <= 1'b1;
        @(posedge ref_clk);
        ais <= 1'b0;
        rchk(7'h18, 8'h80, 8'h00);
        lp.sendBits(32'h000000A5, 8);
        rchk(7'h50, 8'hFF, 8'hA5);
        rchk(7'h18, 8'h0A, 8'h0A);
        wb(7'h19, 1'b1, 8'h10);
        wb(7'h18, 1'b0, 8'h00);
        lp.sendBits(32'h000000FF, 8);
        @(posedge ref_clk);
        check({31'h0, intOut}, 32'h1);
        rchk(7'h18, 8'h10, 8'h10);
        check({31'h0, intOut}, 32'h0);
        wb(7'h19, 1'b1, 8'h00);
        lp.sendBits(32'h000001FE, 9);
        @(posedge ref_clk);
        check({31'h0, intOut}, 32'h0);
        rchk(7'h18, 8'h10, 8'h10);
        lp.sendBits(32'h00000000, 28);
        rchk(7'h18, 8'h20, 8'h00);
        lp.sendBits(32'h00000000, 2);
        rchk(7'h18, 8'h20, 8'h20);
        t1Mode <= 1'b1;
        wb(7'h19, 1'b1, 8'h01);
        for (f = 3'd0; f < 3'd4; f = f + 3'd1)
        begin
            wb(7'h1F, 1'b1, {3'b000, 2'b10, f[1:0], 1'b0});
            wb(7'h1F, 1'b1, {3'b000, 2'b11, f[1:0], 1'b0});
            rchk(7'h50, 8'hFF, 8'h3F);
            wb(7'h18, 1'b0, 8'h00);
            for (k = 4'd0; k < {f, 1'b0}; k = k + 4'd1)
                lp.sendBits({17'h00000, 3'b001, f, 1'b0, 8'hFF}, 16);
            rchk(7'h18, 8'h01, 8'h00);
            lp.sendBits({17'h00000, 3'b001, f, 1'b0, 8'hFF}, 16);
            @(posedge ref_clk);
            check({31'h0, intOut}, 32'h1);
            rchk(7'h18, 8'h01, 8'h01);
            rchk(7'h50, 8'hFF, {5'b00001, f});
        end
        summarize;
    end
endmodule

// file: bench/t1_code_props.sv
// Port-level assertions for the T1 code controller
`timescale 1ns/1ps
module t1_code_props (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        nrst,
    // Register bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [8:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Data link and interrupt
    input wire logic        txBitStb,
    input wire logic        txLinkBit,
    input wire logic        rxBitStb,
    input wire logic        rxBitIn,
    input wire logic        intOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] mask_r;
    logic       rxEna_r;
    logic [3:0] ones_r;
    wire        take = cyc_i && stb_i && !ack_o;
    wire        wrLow = take && we_i && sel_i[0];
    ////////////////////////////////////////////////////////////////////////
    // Shadows of host writes and the run of received ones
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mask_r <= 8'h00;
            rxEna_r <= 1'b0;
            ones_r <= 4'h0;
        end
        else
        begin
            if (wrLow && adr_i[8:2] == 7'h19)
                mask_r <= dat_i[7:0];
            if (wrLow && adr_i[8:2] == 7'h1F)
                rxEna_r <= dat_i[4];
            if (rxBitStb)
                ones_r <= rxBitIn ? ones_r + {3'h0, ones_r != 4'h8} : 4'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence rdTaken(idx);
        take && !we_i && adr_i[8:2] == idx;
    endsequence
    sequence eighthOne;
        rxBitStb && rxBitIn && ones_r == 4'h7;
    endsequence
    ack_next_a: assert property (take |=> ack_o)
        else $error("request not acknowledged in the next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("read data above bit 7 not zero");
    tx_hold_a: assert property (!txBitStb |=> $stable(txLinkBit))
        else $error("link bit moved without a strobe");
    int_mask_a: assert property (intOut |-> $past(mask_r) != 8'h00)
        else $error("interrupt high with every event masked");
    abort_int_a: assert property (
        eighthOne ##0 mask_r[4] |-> ##[1:2] intOut)
        else $error("unmasked abort did not raise the interrupt");
    rx_high_zero_a: assert property (
        rdTaken(7'h50) ##0 rxEna_r |=> dat_o[7:6] == 2'b00)
        else $error("receive byte top bits set in code mode");
    mask_read_a: assert property (
        rdTaken(7'h19) |=> dat_o[7:0] == mask_r)
        else $error("mask read back differs from last write");
endmodule
bind t1_code_controller t1_code_props chk (
    .ref_clk(ref_clk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .txBitStb(txBitStb),
    .txLinkBit(txLinkBit), .rxBitStb(rxBitStb), .rxBitIn(rxBitIn),
    .intOut(intOut)
);

// file: core/code_ctrl_map.vh
// Register indices, field positions, reset values and counts
`ifndef CODE_CTRL_MAP_VH
`define CODE_CTRL_MAP_VH

// Register indices (byte address is four times the index)
`define IDX_LINK_EVENT_STATUS  7'h18
`define IDX_LINK_EVENT_MASK    7'h19
`define IDX_CODE_CONTROL       7'h1F
`define IDX_RECEIVE_LINK_BYTE  7'h50
`define IDX_TRANSMIT_LINK_BYTE 7'h51
`define IDX_LINK_MATCH_ONE     7'h52
`define IDX_LINK_MATCH_TWO     7'h53

// Reset values
`define RST_BYTE               8'h00
`define RST_CODE_ALL_ONES      6'h3F

// Code control fields
`define CC_SEND_CODE           0
`define CC_FILTER_LOW          1
`define CC_FILTER_HIGH         2
`define CC_RX_RESET            3
`define CC_RX_ENABLE           4
`define CC_USED_MASK           8'h1F

// Link event status bits
`define EV_CODE_CHANGE         0
`define EV_LINK_MATCH          1
`define EV_TX_EMPTY            2
`define EV_RX_FULL             3
`define EV_ABORT               4
`define EV_CODE_CLEAR          5
`define EV_TX_CLK_LOSS         6
`define EV_ALARM_CI            7

// Link framing
`define FLAG_ONES              8'hFF
`define CODE_SEQ_LEN           5'd16
`define BYTE_LEN               5'd8
`define ABORT_ONES             4'd8
`define CLEAR_BITS             5'd30
`define CLK_LOSS_PERIODS       4'd15

// Filter counts for settings 00, 01, 10, 11
`define FILT_NONE              3'd1
`define FILT_THREE             3'd3
`define FILT_FIVE              3'd5
`define FILT_SEVEN             3'd7

`endif

// file: core/t1_code_controller.v
// T1 bit-oriented code generator, detector and data-link event flags
`timescale 1ns/1ps
`include "code_ctrl_map.vh"

//
// Overview of operation
// - Code send and detection work only while T1 mode is selected.
// - Transmitted code comes from bits 0 to 5 of transmit link byte.
// - Send-code bit set starts code sequence at once; repeats while set.
// - Generator inserts the all-ones abort flag by itself.
// - Receive-code enable makes receive link byte report codes.
// - Enabling detection presets the six code bits to all ones.
// - New valid code sets code change event.
// - Filter field needs none, three, five or seven equal codes.
// - Rising edge of receive reset bit resets the detector.
// - Bits 6 and 7 of receive link byte are zero in code mode.
// - Receive byte equal to either match pattern sets match event.
// - Transmit byte taken into the shifter sets empty event.
// - Eight consecutive received ones set abort event.
// - Thirty link bits without abort set code clear event.
// - No tx clock edge for 15 scaled periods sets loss event.
// - Alarm-CI detection sets its event in T1 mode only.
// - Transmit link byte goes out a byte at a time, LSB first.
// - Mask bit 1 lets its event reach the interrupt.
module t1_code_controller #(
    parameter SCALED_DIV = 13
)(
    // Clock and reset
    input  wire       ref_clk,
    input  wire       nrst,
    // Wishbone slave
    input  wire       cyc_i,
    input  wire       stb_i,
    input  wire       we_i,
    input  wire [8:0] adr_i,
    input  wire [3:0] sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg        ack_o,
    // Mode and pins
    input  wire       t1ModePin,
    input  wire       txClockPin,
    // Transmit data link
    input  wire       txBitStb,
    output reg        txLinkBit,
    // Receive data link
    input  wire       rxBitStb,
    input  wire       rxBitIn,
    input  wire       aisCiDetect,
    // Interrupt
    output reg        intOut
);

////////////////////////////////////////////////////////////////////////////
// Functions
function [2:0] filterNeed;
    input [1:0] sel;
    begin
        case (sel)
            2'b00:   filterNeed = `FILT_NONE;
            2'b01:   filterNeed = `FILT_THREE;
            2'b10:   filterNeed = `FILT_FIVE;
            default: filterNeed = `FILT_SEVEN;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Declarations
reg  [7:0]  status_r;
reg  [7:0]  mask_r;
reg  [7:0]  control_r;
reg  [7:0]  txByte_r;
reg  [7:0]  match1_r;
reg  [7:0]  match2_r;
reg  [7:0]  rxByte_r;
reg  [5:0]  rxCode_r;
reg  [5:0]  candCode_r;
reg  [2:0]  candCnt_r;
reg  [15:0] rxShift_r;
reg  [2:0]  rxBits_r;
reg  [3:0]  onesCnt_r;
reg  [4:0]  clearCnt_r;
reg  [15:0] txShift_r;
reg  [4:0]  txLeft_r;
reg         txCodeMode_r;
reg         rstPrev_r;
reg         enPrev_r;
reg  [2:0]  modeSync_r;
reg         t1Mode_r;
reg  [2:0]  clkSync_r;
reg         clkLevel_r;
reg  [7:0]  divCnt_r;
reg  [3:0]  lossCnt_r;
reg  [7:0]  events;
reg  [7:0]  readClr;
wire [6:0]  regIdx    = adr_i[8:2];
wire        busReq    = cyc_i & stb_i & ~ack_o;
wire        busWr     = busReq & we_i & sel_i[0];
wire        busRd     = busReq & ~we_i;
wire        codeEn    = control_r[`CC_RX_ENABLE] & t1Mode_r;
wire        sendReq   = control_r[`CC_SEND_CODE] & t1Mode_r;
wire        rxResetEdge = control_r[`CC_RX_RESET] & ~rstPrev_r;
wire [15:0] rxWin     = {rxBitIn, rxShift_r[15:1]};
wire        codeSeen  = rxWin[7:0] == `FLAG_ONES && !rxWin[8] && !rxWin[15];
wire [5:0]  seenCode  = rxWin[14:9];
wire [7:0]  rxAsm     = rxWin[15:8];
wire [7:0]  rxView    = codeEn ? {2'b00, rxCode_r} : rxByte_r;
wire        clkEdge   = (clkSync_r[2] == clkSync_r[1]) &&
                        (clkSync_r[1] != clkLevel_r);
wire        scaledTick = divCnt_r == SCALED_DIV - 1;
wire        txReload  = txLeft_r == 5'd0 || (sendReq != txCodeMode_r);

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: a change counts once second and third stages agree
always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        modeSync_r <= 3'h0;
        t1Mode_r   <= 1'b0;
        clkSync_r  <= 3'h0;
        clkLevel_r <= 1'b0;
    end
    else
    begin
        modeSync_r <= {modeSync_r[1:0], t1ModePin};
        clkSync_r  <= {clkSync_r[1:0], txClockPin};
        if (modeSync_r[2] == modeSync_r[1])
            t1Mode_r <= modeSync_r[1];
        if (clkSync_r[2] == clkSync_r[1])
            clkLevel_r <= clkSync_r[1];
    end
end

////////////////////////////////////////////////////////////////////////////
// Wishbone slave: one wait-free answer, unmapped reads return zero
always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        ack_o     <= 1'b0;
        dat_o     <= 32'h0000_0000;
        mask_r    <= `RST_BYTE;
        control_r <= `RST_BYTE;
        txByte_r  <= `RST_BYTE;
        match1_r  <= `RST_BYTE;
        match2_r  <= `RST_BYTE;
    end
    else
    begin
        ack_o <= busReq;
        if (busRd)
        begin
            case (regIdx)
                `IDX_LINK_EVENT_STATUS:  dat_o <= {24'h0, status_r};
                `IDX_LINK_EVENT_MASK:    dat_o <= {24'h0, mask_r};
                `IDX_CODE_CONTROL:       dat_o <= {24'h0, control_r};
                `IDX_RECEIVE_LINK_BYTE:  dat_o <= {24'h0, rxView};
                `IDX_TRANSMIT_LINK_BYTE: dat_o <= {24'h0, txByte_r};
                `IDX_LINK_MATCH_ONE:     dat_o <= {24'h0, match1_r};
                `IDX_LINK_MATCH_TWO:     dat_o <= {24'h0, match2_r};
                default:                 dat_o <= 32'h0000_0000;
            endcase
        end
        if (busWr)
        begin
            case (regIdx)
                `IDX_LINK_EVENT_MASK:    mask_r    <= dat_i[7:0];
                `IDX_CODE_CONTROL:
                    control_r <= dat_i[7:0] & `CC_USED_MASK;
                `IDX_TRANSMIT_LINK_BYTE: txByte_r  <= dat_i[7:0];
                `IDX_LINK_MATCH_ONE:     match1_r  <= dat_i[7:0];
                `IDX_LINK_MATCH_TWO:     match2_r  <= dat_i[7:0];
                default:                 mask_r    <= mask_r;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Transmit: code sequence or link byte, LSB first
always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        txShift_r    <= 16'h0000;
        txLeft_r     <= 5'd0;
        txCodeMode_r <= 1'b0;
        txLinkBit    <= 1'b1;
    end
    else if (txBitStb)
    begin
        if (txReload)
        begin
            txCodeMode_r <= sendReq;
            if (sendReq)
            begin
                // Flag of ones, zero, code, zero
                txLinkBit <= 1'b1;
                txShift_r <= {1'b0, 1'b0, txByte_r[5:0], 1'b0,
                              7'h7F};
                txLeft_r  <= `CODE_SEQ_LEN - 5'd1;
            end
            else
            begin
                txLinkBit <= txByte_r[0];
                txShift_r <= {9'h000, txByte_r[7:1]};
                txLeft_r  <= `BYTE_LEN - 5'd1;
            end
        end
        else
        begin
            txLinkBit <= txShift_r[0];
            txShift_r <= {1'b0, txShift_r[15:1]};
            txLeft_r  <= txLeft_r - 5'd1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Receive: byte assembly, code filter, abort and clear counting
always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        rxShift_r  <= 16'h0000;
        rxBits_r   <= 3'd0;
        rxByte_r   <= `RST_BYTE;
        rxCode_r   <= `RST_CODE_ALL_ONES;
        candCode_r <= `RST_CODE_ALL_ONES;
        candCnt_r  <= 3'd0;
        onesCnt_r  <= 4'd0;
        clearCnt_r <= 5'd0;
        rstPrev_r  <= 1'b0;
        enPrev_r   <= 1'b0;
    end
    else
    begin
        rstPrev_r <= control_r[`CC_RX_RESET];
        enPrev_r  <= codeEn;
        if (rxResetEdge || (codeEn && !enPrev_r))
        begin
            rxCode_r   <= `RST_CODE_ALL_ONES;
            candCode_r <= `RST_CODE_ALL_ONES;
            candCnt_r  <= 3'd0;
            rxShift_r  <= 16'h0000;
        end
        else if (rxBitStb)
        begin
            rxShift_r <= rxWin;
            rxBits_r  <= rxBits_r + 3'd1;
            if (rxBits_r == 3'd7 && !codeEn)
                rxByte_r <= rxWin[15:8];
            if (codeEn && codeSeen)
            begin
                if (seenCode != candCode_r)
                begin
                    candCode_r <= seenCode;
                    candCnt_r  <= 3'd1;
                    if (filterNeed(control_r[2:1]) == 3'd1)
                        rxCode_r <= seenCode;
                end
                else if (candCnt_r < 3'd7)
                begin
                    candCnt_r <= candCnt_r + 3'd1;
                    if (candCnt_r + 3'd1 >= filterNeed(control_r[2:1]))
                        rxCode_r <= seenCode;
                end
            end
            if (rxBitIn)
                onesCnt_r <= (onesCnt_r == `ABORT_ONES) ?
                             `ABORT_ONES : onesCnt_r + 4'd1;
            else
                onesCnt_r <= 4'd0;
            if (rxBitIn && onesCnt_r == `ABORT_ONES - 4'd1)
                clearCnt_r <= 5'd0;
            else if (clearCnt_r != `CLEAR_BITS)
                clearCnt_r <= clearCnt_r + 5'd1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Transmit clock watchdog on the scaled master clock
always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        divCnt_r  <= 8'd0;
        lossCnt_r <= 4'd0;
    end
    else
    begin
        divCnt_r <= scaledTick ? 8'd0 : divCnt_r + 8'd1;
        if (clkEdge)
            lossCnt_r <= 4'd0;
        else if (scaledTick && lossCnt_r != `CLK_LOSS_PERIODS)
            lossCnt_r <= lossCnt_r + 4'd1;
    end
end

////////////////////////////////////////////////////////////////////////////
// Event detection
always @*
begin
    events = 8'h00;
    events[`EV_CODE_CHANGE] = rxBitStb && codeEn && codeSeen &&
        seenCode != rxCode_r &&
        ((seenCode != candCode_r && filterNeed(control_r[2:1]) == 3'd1) ||
         (seenCode == candCode_r && candCnt_r < 3'd7 &&
          candCnt_r + 3'd1 >= filterNeed(control_r[2:1])));
    events[`EV_LINK_MATCH] = rxBitStb && rxBits_r == 3'd7 && !codeEn &&
        (rxAsm == match1_r || rxAsm == match2_r);
    events[`EV_TX_EMPTY] = txBitStb && txReload && !sendReq;
    events[`EV_RX_FULL] = rxBitStb && rxBits_r == 3'd7 && !codeEn;
    events[`EV_ABORT] = rxBitStb && rxBitIn &&
        onesCnt_r == `ABORT_ONES - 4'd1;
    events[`EV_CODE_CLEAR] = rxBitStb && clearCnt_r == `CLEAR_BITS - 5'd1 &&
        !(rxBitIn && onesCnt_r == `ABORT_ONES - 4'd1);
    events[`EV_TX_CLK_LOSS] = scaledTick && !clkEdge &&
        lossCnt_r == `CLK_LOSS_PERIODS - 4'd1;
    events[`EV_ALARM_CI] = aisCiDetect && t1Mode_r;
end

always @*
begin
    readClr = 8'h00;
    if (busRd && regIdx == `IDX_LINK_EVENT_STATUS)
        readClr = status_r;
end

////////////////////////////////////////////////////////////////////////////
// Sticky status, cleared by read; a new event wins over the clear
always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        status_r <= `RST_BYTE;
        intOut   <= 1'b0;
    end
    else
    begin
        status_r <= (status_r & ~readClr) | events;
        intOut   <= |(((status_r & ~readClr) | events) & mask_r);
    end
end

endmodule
